// [rtl/mpc_consts.svh]
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// Register indices; byte address is four times the index
`define MPC_IDX_PROFILE      8'h98
`define MPC_IDX_ALGVAR       8'h9A
`define MPC_RESET_PROFILE    32'h00000000
`define MPC_RESET_ALGVAR     32'h00000000

// Step profile word layout
`define MPC_PARITY_BIT       31
`define MPC_STEP0_LSB        28
`define MPC_STEP_PITCH       3
`define MPC_ADV_LSB          5

// Algorithm variable word layout
`define MPC_HANDOVER_LSB     22
`define MPC_NEG_LIMIT_LSB    16
`define MPC_HYST_BIT         15
`define MPC_EMF_LSB          10
`define MPC_ISD_CYC_LSB      7
`define MPC_ZC_LSB           2
`define MPC_DIV_LSB          0

// Duty in hundredths of a percent
`define MPC_DUTY_C0          14'h0000
`define MPC_DUTY_C1          14'h1388
`define MPC_DUTY_C2          14'h1D4C
`define MPC_DUTY_C3          14'h20B7
`define MPC_DUTY_C4          14'h222E
`define MPC_DUTY_C5          14'h249F
`define MPC_DUTY_C6          14'h2616
`define MPC_DUTY_C7          14'h26AC

// Decoded setting scales
`define MPC_ADV_STEP_DEG     4'h5
`define MPC_HANDOVER_BASE    5'h03
`define MPC_ISD_CYC_BASE     5'h02
`define MPC_ISD_CYC_STEP     5'h03
`define MPC_EMF_STEP         13'h00C8
`define MPC_ZC_DEG_0         4'h5
`define MPC_ZC_DEG_1         4'h8
`define MPC_ZC_DEG_2         4'hC
`define MPC_ZC_DEG_3         4'hF

// AXI responses
`define MPC_RESP_OKAY        2'h0
`define MPC_RESP_SLVERR      2'h2

`endif

// [rtl/mpc_pkg.sv]
`default_nettype none
package mpc_pkg;
  typedef logic [2:0]  mpc_duty_code_t;
  typedef logic [13:0] mpc_duty_t;
  typedef logic [7:0][13:0] mpc_duty_set_t;
  typedef logic [31:0] mpc_word_t;
endpackage
`default_nettype wire

// [rtl/mpc_duty_decode.sv]
`include "mpc_consts.svh"
`default_nettype none
module mpc_duty_decode
  import mpc_pkg::*;
(
  // Step code in, duty out
  input  wire mpc_duty_code_t code,
  output mpc_duty_t           duty
);
  always_comb begin
    case (code)
      3'h0:    duty = `MPC_DUTY_C0;
      3'h1:    duty = `MPC_DUTY_C1;
      3'h2:    duty = `MPC_DUTY_C2;
      3'h3:    duty = `MPC_DUTY_C3;
      3'h4:    duty = `MPC_DUTY_C4;
      3'h5:    duty = `MPC_DUTY_C5;
      3'h6:    duty = `MPC_DUTY_C6;
      3'h7:    duty = `MPC_DUTY_C7;
      default: duty = `MPC_DUTY_C0;
    endcase
  end
endmodule
`default_nettype wire

// [rtl/mpc_profile_regs.sv]
`include "mpc_consts.svh"
`default_nettype none
module mpc_profile_regs
  import mpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Raw register words
  output mpc_word_t              three_phase_step_profile,
  output mpc_word_t              algorithm_variable_config,
  // Decoded step profile
  output mpc_duty_set_t          three_phase_duty,
  output logic [3:0]             commutation_advance_deg,
  // Decoded algorithm variables
  output logic [4:0]             open_loop_handover_count,
  output logic [2:0]             surge_guard_negative_limit,
  output logic                   surge_guard_hysteresis,
  output logic [12:0]            initial_speed_emf_threshold,
  output logic [4:0]             initial_speed_cycle_threshold,
  output logic [3:0]             open_loop_zero_cross_deg,
  output logic [1:0]             quick_launch_divider
);

  // Decode compares word index bits above the byte lane
  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W too small to reach the register indices");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              aw_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              w_got;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    mpc_word_t         profile;
    mpc_word_t         algvar;
    mpc_duty_set_t     duty;
    logic [3:0]        adv_deg;
    logic [4:0]        handover;
    logic [2:0]        neg_limit;
    logic              hyst;
    logic [12:0]       emf_thr;
    logic [4:0]        isd_cyc;
    logic [3:0]        zc_deg;
    logic [1:0]        div;
  } mpc_state_t;

  mpc_state_t    st;
  mpc_state_t    next_st;
  mpc_duty_set_t duty_w;

  function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    idx_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // Byte lanes not strobed keep their old contents
  function automatic mpc_word_t merge(input mpc_word_t   old,
                                      input logic [31:0] data,
                                      input logic [3:0]  strb);
    mpc_word_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  function automatic logic [2:0] field3(input mpc_word_t w,
                                        input int        lsb);
    field3 = w[lsb +: 3];
  endfunction

  // Advance grows in equal steps per code
  function automatic logic [3:0] adv_of(input logic [1:0] code);
    adv_of = 4'(code * `MPC_ADV_STEP_DEG);
  endfunction

  // Handover count doubles per code from the base count
  function automatic logic [4:0] handover_of(input logic [1:0] code);
    handover_of = 5'(`MPC_HANDOVER_BASE << code);
  endfunction

  function automatic logic [12:0] emf_of(input logic [4:0] code);
    emf_of = 13'(code * `MPC_EMF_STEP);
  endfunction

  function automatic logic [4:0] isd_cyc_of(input logic [2:0] code);
    isd_cyc_of = 5'(`MPC_ISD_CYC_BASE + code * `MPC_ISD_CYC_STEP);
  endfunction

  // Angles are unevenly spaced, so a table rather than a product
  function automatic logic [3:0] zc_of(input logic [1:0] code);
    case (code)
      2'h0:    zc_of = `MPC_ZC_DEG_0;
      2'h1:    zc_of = `MPC_ZC_DEG_1;
      2'h2:    zc_of = `MPC_ZC_DEG_2;
      2'h3:    zc_of = `MPC_ZC_DEG_3;
      default: zc_of = `MPC_ZC_DEG_0;
    endcase
  endfunction

  // One decoder per step; duty lags the register by one cycle
  for (genvar k = 0; k < 8; k++) begin : g_step
    mpc_duty_decode u_dec (
      .code (field3(st.profile,
                    `MPC_STEP0_LSB - k * `MPC_STEP_PITCH)),
      .duty (duty_w[k])
    );
  end

  always_comb begin
    logic              aw_hs;
    logic              w_hs;
    logic              have_aw;
    logic              have_w;
    logic [ADDR_W-1:0] waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    aw_hs   = s_axi_awvalid && st.awready;
    w_hs    = s_axi_wvalid && st.wready;
    have_aw = st.aw_got || aw_hs;
    have_w  = st.w_got || w_hs;
    waddr   = aw_hs ? s_axi_awaddr : st.awaddr;
    wdata   = w_hs ? s_axi_wdata : st.wdata;
    wstrb   = w_hs ? s_axi_wstrb : st.wstrb;
    next_st = st;

    // Write address and data may arrive in either order
    if (aw_hs) begin
      next_st.awaddr = s_axi_awaddr;
      next_st.aw_got = 1'b1;
    end
    if (w_hs) begin
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.w_got = 1'b1;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (have_aw && have_w && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `MPC_RESP_OKAY;
      // Strobed byte lanes are stored whole, parity and reserved bits included
      if (idx_hit(waddr, `MPC_IDX_PROFILE)) begin
        next_st.profile = merge(st.profile, wdata, wstrb);
      end else if (idx_hit(waddr, `MPC_IDX_ALGVAR)) begin
        next_st.algvar = merge(st.algvar, wdata, wstrb);
      end else begin
        next_st.bresp = `MPC_RESP_SLVERR;
      end
    end
    // Each ready only while its own channel holds nothing and no response waits, so one write at a time
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `MPC_RESP_OKAY;
      if (idx_hit(s_axi_araddr, `MPC_IDX_PROFILE)) begin
        next_st.rdata = st.profile;
      end else if (idx_hit(s_axi_araddr, `MPC_IDX_ALGVAR)) begin
        next_st.rdata = st.algvar;
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = `MPC_RESP_SLVERR;
      end
    end
    next_st.arready = !next_st.rvalid;

    // Decoded settings for the modulation and startup logic
    next_st.duty      = duty_w;
    next_st.adv_deg   = adv_of(st.profile[`MPC_ADV_LSB +: 2]);
    next_st.handover  =
      handover_of(st.algvar[`MPC_HANDOVER_LSB +: 2]);
    next_st.neg_limit = st.algvar[`MPC_NEG_LIMIT_LSB +: 3];
    next_st.hyst      = st.algvar[`MPC_HYST_BIT];
    next_st.emf_thr   = emf_of(st.algvar[`MPC_EMF_LSB +: 5]);
    next_st.isd_cyc   =
      isd_cyc_of(st.algvar[`MPC_ISD_CYC_LSB +: 3]);
    next_st.zc_deg    = zc_of(st.algvar[`MPC_ZC_LSB +: 2]);
    next_st.div       = st.algvar[`MPC_DIV_LSB +: 2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.profile <= `MPC_RESET_PROFILE;
      st.algvar  <= `MPC_RESET_ALGVAR;
    end else begin
      st <= next_st;
    end
  end

  // Protection bits carry no meaning for this block
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  assign s_axi_awready                 = st.awready;
  assign s_axi_wready                  = st.wready;
  assign s_axi_bresp                   = st.bresp;
  assign s_axi_bvalid                  = st.bvalid;
  assign s_axi_arready                 = st.arready;
  assign s_axi_rdata                   = st.rdata;
  assign s_axi_rresp                   = st.rresp;
  assign s_axi_rvalid                  = st.rvalid;
  assign three_phase_step_profile      = st.profile;
  assign algorithm_variable_config     = st.algvar;
  assign three_phase_duty              = st.duty;
  assign commutation_advance_deg       = st.adv_deg;
  assign open_loop_handover_count      = st.handover;
  assign surge_guard_negative_limit    = st.neg_limit;
  assign surge_guard_hysteresis        = st.hyst;
  assign initial_speed_emf_threshold   = st.emf_thr;
  assign initial_speed_cycle_threshold = st.isd_cyc;
  assign open_loop_zero_cross_deg      = st.zc_deg;
  assign quick_launch_divider          = st.div;

endmodule
`default_nettype wire

// [verification/mpc_profile_assertions.sv]
`default_nettype none
module mpc_profile_checker
  import mpc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Bus handshakes
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [1:0]    s_axi_bresp,
  // Register words and decodes
  input wire mpc_word_t     three_phase_step_profile,
  input wire mpc_word_t     algorithm_variable_config,
  input wire mpc_duty_set_t three_phase_duty,
  input wire logic [3:0]    commutation_advance_deg,
  input wire logic [4:0]    open_loop_handover_count,
  input wire logic          surge_guard_hysteresis
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0][13:0] DT = {14'h26AC, 14'h2616, 14'h249F,
    14'h222E, 14'h20B7, 14'h1D4C, 14'h1388, 14'h0000};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_step0_duty: assert property ($past(aresetn) |->
    three_phase_duty[0] == DT[$past(three_phase_step_profile[30:28])])
    else $error("step 0 duty wrong");
  a_step3_duty: assert property ($past(aresetn) |->
    three_phase_duty[3] == DT[$past(three_phase_step_profile[21:19])])
    else $error("step 3 duty wrong");
  a_step4_ratio: assert property ($past(aresetn) |->
    three_phase_duty[4] == DT[$past(three_phase_step_profile[18:16])])
    else $error("step 4 duty wrong");
  a_step7_duty: assert property ($past(aresetn) |->
    three_phase_duty[7] == DT[$past(three_phase_step_profile[9:7])])
    else $error("step 7 duty wrong");
  a_advance_deg: assert property ($past(aresetn) |->
    commutation_advance_deg == 4'h5 * $past(three_phase_step_profile[6:5]))
    else $error("advance angle wrong");
  a_words_reset: assert property (!$past(aresetn) |->
    algorithm_variable_config == 32'h0 && three_phase_step_profile == 32'h0)
    else $error("word not zero after reset");
  a_handover_cnt: assert property ($past(aresetn) |->
    open_loop_handover_count ==
      (5'h03 << $past(algorithm_variable_config[23:22])))
    else $error("handover count wrong");
  a_hyst_bit: assert property ($past(aresetn) |->
    surge_guard_hysteresis == $past(algorithm_variable_config[15]))
    else $error("hysteresis wrong");
  a_word_only_write: assert property (
    $past(aresetn) && !$rose(s_axi_bvalid)
    |-> $stable(three_phase_step_profile))
    else $error("word changed without write");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
endmodule
`default_nettype wire

// [verification/modulation_profile_config_bench.sv]
`default_nettype none
module modulation_profile_config_bench;
  import mpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0][13:0] DT = {14'h26AC, 14'h2616, 14'h249F,
    14'h222E, 14'h20B7, 14'h1D4C, 14'h1388, 14'h0000};
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, hyst;
  logic [1:0] s_axi_bresp, s_axi_rresp, div;
  mpc_word_t prof, algv;
  mpc_duty_set_t duty;
  logic [3:0] adv, zc;
  logic [4:0] hand, cyc;
  logic [2:0] neg;
  logic [12:0] emf;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  always #5 aclk = ~aclk;
  mpc_profile_regs #(.ADDR_W(12)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .three_phase_step_profile(prof),
    .algorithm_variable_config(algv), .three_phase_duty(duty),
    .commutation_advance_deg(adv), .open_loop_handover_count(hand),
    .surge_guard_negative_limit(neg), .surge_guard_hysteresis(hyst),
    .initial_speed_emf_threshold(emf),
    .initial_speed_cycle_threshold(cyc),
    .open_loop_zero_cross_deg(zc), .quick_launch_divider(div));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    // Whole run needs well under a thousand cycles
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Lag holds the response ready low for that many edges
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er,
                    input int lag = 0);
    logic done;
    int   n;
    done = 0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
        done = 1;
      end else if (n == lag) begin
        s_axi_bready <= 1'b1;
      end
    end
    // An idle edge keeps the next call from re-driving in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er, input int lag = 0);
    logic done;
    int   n;
    done = 0;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(s_axi_rresp, er);
        done = 1;
      end else if (n == lag) begin
        s_axi_rready <= 1'b1;
      end
    end
    @(posedge aclk);
  endtask
  task automatic alg_chk(input logic [31:0] w, input logic [4:0] h,
                         input logic [12:0] e, input logic [4:0] c,
                         input logic [3:0] z);
    wr(12'h268, w, 4'hF, 2'h0);
    rd(12'h268, w, 2'h0);
    repeat (2) @(posedge aclk);
    check(algv, w);
    check(hand, h);
    check(emf, e);
    check(cyc, c);
    check(zc, z);
    check({neg, hyst, div}, {w[18:15], w[1:0]});
  endtask
  task automatic t_duty();
    logic [31:0] w;
    logic [2:0]  s;
    for (int c = 0; c < 8; c++) begin
      w = {c[0], 24'h000000, c[1:0], 5'h15};
      // Every step gets a different code so a misplaced field shows
      for (int k = 0; k < 8; k++) begin
        s = 3'(c + k);
        w[28 - 3 * k +: 3] = s;
      end
      wr(12'h260, w, 4'hF, 2'h0);
      rd(12'h260, w, 2'h0);
      repeat (2) @(posedge aclk);
      for (int k = 0; k < 8; k++) begin
        s = 3'(c + k);
        check(duty[k], DT[s]);
      end
      check(adv, 4'h5 * c[1:0]);
    end
    $display("duty profile test done");
  endtask
  task automatic t_reset_values();
    rd(12'h260, 32'h0, 2'h0);
    rd(12'h268, 32'h0, 2'h0);
    check({hand, cyc, zc}, {5'h03, 5'h02, 4'h5});
    check(prof, 32'h0);
    check(algv, 32'h0);
    $display("reset value test done");
  endtask
  task automatic t_edges();
    wr(12'h264, 32'h0, 4'hF, 2'h2, 3);
    rd(12'h264, 32'h0, 2'h2, 3);
    wr(12'h260, 32'hFFFFFFF5, 4'hF, 2'h0);
    wr(12'h260, 32'h0, 4'h2, 2'h0);
    rd(12'h260, 32'hFFFF00F5, 2'h0);
    check(prof, 32'hFFFF00F5);
    $display("strobe and unmapped test done");
  endtask
  task automatic t_reset_mid();
    wr(12'h268, 32'hFFFFFFFF, 4'hF, 2'h0);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    t_duty();
    alg_chk(32'hFFFFFFFF, 5'h18, 13'h1838, 5'h17, 4'hF);
    alg_chk(32'h00450486, 5'h06, 13'h00C8, 5'h05, 4'h8);
    alg_chk(32'h0082A989, 5'h0C, 13'h07D0, 5'h0B, 4'hC);
    $display("algorithm variable test done");
    t_edges();
    t_reset_mid();
    report_and_stop();
  end
endmodule
bind mpc_profile_regs mpc_profile_checker #(.ADDR_W(ADDR_W)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .three_phase_step_profile(three_phase_step_profile),
  .algorithm_variable_config(algorithm_variable_config),
  .three_phase_duty(three_phase_duty),
  .commutation_advance_deg(commutation_advance_deg),
  .open_loop_handover_count(open_loop_handover_count),
  .surge_guard_hysteresis(surge_guard_hysteresis));
`default_nettype wire
